// >>> logic/ecm_pkg.sv
// Package: register map, mode codes and field layout of the capture unit
package ecm_pkg;

  // ----------------------------------------------------------------
  // Register map (word addresses of the Avalon-MM slave)
  // ----------------------------------------------------------------
  localparam logic [2:0] ADDR_CONTROL = 3'h0;
  localparam logic [2:0] ADDR_CCL = 3'h1;
  localparam logic [2:0] ADDR_CCH = 3'h2;
  localparam logic [2:0] ADDR_FLAG = 3'h3;
  localparam logic [2:0] ADDR_PIN_DIR = 3'h4;

  // ----------------------------------------------------------------
  // Control register fields and reset values
  // ----------------------------------------------------------------
  localparam int CTL_CFG_BIT = 7;
  localparam int CTL_DUTY_LSB = 4;
  localparam logic [7:0] CTL_WRITE_MASK = 8'hBF;
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [15:0] CC_RESET = 16'h0000;
  localparam logic PIN_DIR_RESET = 1'b1;
  localparam logic [31:0] UNMAPPED_DATA = 32'h00000000;

  // ----------------------------------------------------------------
  // Mode codes of the mode field
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    MODE_OFF = 4'b0000,
    MODE_RSV1 = 4'b0001,
    MODE_CMP_TOGGLE = 4'b0010,
    MODE_RSV3 = 4'b0011,
    MODE_CAP_FALL = 4'b0100,
    MODE_CAP_RISE = 4'b0101,
    MODE_CAP_RISE4 = 4'b0110,
    MODE_CAP_RISE16 = 4'b0111,
    MODE_CMP_SET = 4'b1000,
    MODE_CMP_CLEAR = 4'b1001,
    MODE_CMP_SWI = 4'b1010,
    MODE_CMP_SPECIAL = 4'b1011,
    MODE_PWM_HH = 4'b1100,
    MODE_PWM_HL = 4'b1101,
    MODE_PWM_LH = 4'b1110,
    MODE_PWM_LL = 4'b1111
  } ecm_mode_e;

  localparam logic [3:0] PRESCALE_4_LAST = 4'h3;
  localparam logic [3:0] PRESCALE_16_LAST = 4'hF;
  localparam logic [7:0] DEAD_BAND_RESET = 8'h01;

  // Control register as a packed struct
  typedef struct packed {
    logic output_config_select;
    logic unused6;
    logic [1:0] duty_fraction_bits;
    logic [3:0] unit_mode_select;
  } ecm_control_s;

  // Pin-facing outputs travel together
  typedef struct packed {
    logic primary_output;
    logic primary_oe;
    logic secondary_output;
    logic secondary_oe;
  } ecm_pins_s;

  // Whole state of the unit
  typedef struct packed {
    ecm_control_s ctl;
    logic [15:0] cc;
    logic [1:0] duty_latch;
    logic flag;
    logic pin_dir;
    logic [2:0] pin_sync;
    logic [3:0] prescale;
    logic cmp_latch;
    logic match_d;
    logic special_pending;
    logic timer1_reset;
    logic adc_start;
    logic pwm_level;
    logic [7:0] dead_cnt;
    logic a_level;
    logic b_level;
    ecm_pins_s pins;
    logic waitreq;
    logic [31:0] rdata;
  } ecm_state_s;

endpackage

// >>> logic/ecm_unit.sv
// Enhanced capture/compare/PWM unit with Avalon-MM register slave
//
// Local design decisions: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ps

// Operation
// RQ1: Mode zero switches unit off, resets state
// RQ2: Falling and rising edge capture modes decoded
// RQ3: Fourth and sixteenth edge capture via prescaler
// RQ4: Compare toggles, sets or clears, sets flag
// RQ5: Software interrupt compare sets flag only
// RQ6: Special event: flag, timer reset, converter start
// RQ7: PWM codes pick output polarities
// RQ8: Config bit: single or half-bridge dead-band
// RQ9: Outside PWM config bit ignored
// RQ10: Duty fraction bits feed PWM only
// RQ11: Control bit six reads zero
// RQ12: Capture/compare use timer1, PWM timer2
// RQ13: Capture copies full sixteen-bit timer count
// RQ14: Capture sets flag, software clears it
// RQ15: New capture overwrites, no overrun
// RQ16: Pin driven as output can capture
// RQ17: Software keeps timer1 synchronous
// RQ18: Prescaler cleared when off or not capture
// RQ19: Prescale switch keeps count, may false-fire
// RQ20: Software masks interrupt across mode changes
// RQ21: Trigger at once, timer reset next tick
// RQ22: Pin synchronised, one strobe per edge
// RQ23: Reserved codes behave as off
module ecm_unit
  import ecm_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [2:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [15:0] sixteen_bit_timer_count,
  input wire logic timer1_tick,
  input wire logic [9:0] pwm_time_base,
  input wire logic timer2_period_match,
  input wire logic adc_enabled,
  input wire logic capture_compare_pin_in,
  input wire logic port_data_out,
  output logic timer1_reset_req,
  output logic adc_start_req,
  output logic unit_interrupt_flag,
  output logic primary_output,
  output logic primary_oe,
  output logic secondary_output,
  output logic secondary_oe
);

  ecm_state_s st;
  ecm_state_s next_st;

  // ----------------------------------------------------------------
  // Mode decoding helpers
  // ----------------------------------------------------------------
  function automatic logic is_capture(input logic [3:0] m);
    return m[3:2] == 2'b01;
  endfunction

  function automatic logic is_pwm(input logic [3:0] m);
    return m[3:2] == 2'b11;
  endfunction

  function automatic logic is_compare(input logic [3:0] m);
    return (m == MODE_CMP_TOGGLE) || (m[3:2] == 2'b10);
  endfunction

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  logic [3:0] mode;
  logic pin_level;
  logic rise;
  logic fall;
  logic cap_evt;
  logic match;
  logic match_rise;
  logic [9:0] duty;
  logic bus_hit;
  logic [31:0] rd;

  always_comb begin
    next_st = st;
    mode = st.ctl.unit_mode_select;
    // Pin driven by port latch when configured output, so writes capture
    pin_level = st.pin_dir ? capture_compare_pin_in : port_data_out; // RQ16
    next_st.pin_sync = {st.pin_sync[1:0], pin_level};
    // Only stages 1 and 2 feed the edge detector
    rise = st.pin_sync[1] & ~st.pin_sync[2]; // RQ22
    fall = ~st.pin_sync[1] & st.pin_sync[2]; // RQ22
    cap_evt = 1'b0;
    next_st.adc_start = 1'b0;
    next_st.timer1_reset = 1'b0;

    // Capture event qualification and prescaler
    if (!is_capture(mode)) begin
      next_st.prescale = 4'h0; // RQ18
    end else begin
      unique case (mode)
        MODE_CAP_FALL: cap_evt = fall; // RQ2
        MODE_CAP_RISE: cap_evt = rise; // RQ2
        default: begin
          // Count kept across prescale switches; may fire early
          if (rise) begin
            next_st.prescale = st.prescale + 4'h1; // RQ19
            if (mode == MODE_CAP_RISE4) begin
              cap_evt = st.prescale[1:0] == PRESCALE_4_LAST[1:0]; // RQ3
            end else begin
              cap_evt = st.prescale == PRESCALE_16_LAST; // RQ3
            end
          end
        end
      endcase
    end
    if (cap_evt) begin
      next_st.cc = sixteen_bit_timer_count; // RQ13 RQ15 RQ12
    end

    // Compare match, acted on the first cycle it appears
    match = is_compare(mode) && (sixteen_bit_timer_count == st.cc); // RQ12
    match_rise = match & ~st.match_d;
    next_st.match_d = match;
    if (match_rise) begin
      unique case (mode)
        MODE_CMP_TOGGLE: next_st.cmp_latch = ~st.cmp_latch; // RQ4
        MODE_CMP_SET: next_st.cmp_latch = 1'b1; // RQ4
        MODE_CMP_CLEAR: next_st.cmp_latch = 1'b0; // RQ4
        MODE_CMP_SPECIAL: begin
          next_st.adc_start = adc_enabled; // RQ6 RQ21
          next_st.special_pending = 1'b1;
        end
        default: ; // RQ5
      endcase
    end
    // Timer reset waits for the timer's next tick; lost if match goes away
    if (st.special_pending) begin
      if (!match) begin
        next_st.special_pending = 1'b0;
      end else if (timer1_tick) begin
        next_st.timer1_reset = 1'b1; // RQ6 RQ21
        next_st.special_pending = 1'b0;
      end
    end

    // PWM: duty latched at period end from low byte and fraction bits
    duty = {st.cc[7:0], st.duty_latch};
    if (is_pwm(mode)) begin
      if (timer2_period_match) begin
        next_st.cc[15:8] = st.cc[7:0];
        next_st.duty_latch = st.ctl.duty_fraction_bits; // RQ10
        next_st.pwm_level = (duty != 10'h000); // RQ12
      end else if (pwm_time_base == {st.cc[15:8], st.duty_latch}) begin
        next_st.pwm_level = 1'b0; // RQ12
      end
    end else begin
      next_st.pwm_level = 1'b0;
    end

    // Dead band delays each output's turn-on in half-bridge mode
    if (st.pwm_level != next_st.pwm_level) begin
      next_st.dead_cnt = DEAD_BAND_RESET;
      next_st.a_level = 1'b0;
      next_st.b_level = 1'b0;
    end else if (st.dead_cnt != 8'h00) begin
      next_st.dead_cnt = st.dead_cnt - 8'h01;
    end else begin
      next_st.a_level = st.pwm_level;
      next_st.b_level = ~st.pwm_level;
    end

    // Pin ownership and polarity
    next_st.pins = '0;
    if (is_pwm(mode)) begin
      next_st.pins.primary_oe = 1'b1;
      if (!st.ctl.output_config_select) begin
        next_st.pins.primary_output = st.pwm_level ^ mode[1]; // RQ7 RQ8
      end else begin
        next_st.pins.primary_output = st.a_level ^ mode[1]; // RQ7 RQ8
        next_st.pins.secondary_output = st.b_level ^ mode[0]; // RQ7 RQ8
        next_st.pins.secondary_oe = 1'b1; // RQ8
      end
    end else if (mode == MODE_CMP_TOGGLE || mode == MODE_CMP_SET ||
                 mode == MODE_CMP_CLEAR) begin
      // Config bit ignored; secondary left to the port
      next_st.pins.primary_output = st.cmp_latch; // RQ9 RQ4
      next_st.pins.primary_oe = 1'b1; // RQ9
    end

    // ----------------------------------------------------------------
    // Avalon-MM slave: one wait cycle, answer on the second cycle
    // ----------------------------------------------------------------
    bus_hit = (avs_read | avs_write) & st.waitreq;
    next_st.waitreq = ~bus_hit;
    rd = UNMAPPED_DATA;
    unique case (avs_address)
      ADDR_CONTROL: rd[7:0] = st.ctl & CTL_WRITE_MASK; // RQ11
      ADDR_CCL: rd[7:0] = st.cc[7:0];
      ADDR_CCH: rd[7:0] = st.cc[15:8];
      ADDR_FLAG: rd[0] = st.flag;
      ADDR_PIN_DIR: rd[0] = st.pin_dir;
      default: ;
    endcase
    if (bus_hit && avs_read) begin
      next_st.rdata = rd;
    end
    // Write lands on the accept edge, where the master sees the answer
    if (avs_write && !st.waitreq && avs_byteenable[0]) begin
      unique case (avs_address)
        ADDR_CONTROL: next_st.ctl = avs_writedata[7:0] & CTL_WRITE_MASK;
        ADDR_CCL: next_st.cc[7:0] = avs_writedata[7:0];
        ADDR_CCH: begin
          // High byte is read-only while PWM owns it
          if (!is_pwm(mode)) begin
            next_st.cc[15:8] = avs_writedata[7:0];
          end
        end
        ADDR_FLAG: next_st.flag = avs_writedata[0];
        ADDR_PIN_DIR: next_st.pin_dir = avs_writedata[0];
        default: ;
      endcase
    end

    // Events win over a software clear of the flag
    if (cap_evt || match_rise) begin
      next_st.flag = 1'b1; // RQ14 RQ4 RQ5 RQ6
    end

    // Off and reserved codes clear prescaler, compare latch, pending special event, duty latch and pins
    if (mode == MODE_OFF || mode == MODE_RSV1 || mode == MODE_RSV3) begin
      next_st.prescale = 4'h0; // RQ1 RQ23
      next_st.cmp_latch = 1'b0; // RQ1 RQ23
      next_st.special_pending = 1'b0; // RQ1
      next_st.duty_latch = 2'b00; // RQ1
      next_st.pins = '0; // RQ23
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
      st.ctl <= CTL_RESET;
      st.cc <= CC_RESET;
      st.pin_dir <= PIN_DIR_RESET;
      st.waitreq <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from flip-flops
  assign avs_readdata = st.rdata;
  assign avs_waitrequest = st.waitreq;
  assign timer1_reset_req = st.timer1_reset;
  assign adc_start_req = st.adc_start;
  assign unit_interrupt_flag = st.flag;
  assign primary_output = st.pins.primary_output;
  assign primary_oe = st.pins.primary_oe;
  assign secondary_output = st.pins.secondary_output;
  assign secondary_oe = st.pins.secondary_oe;

endmodule

// >>> bench/ecm_pin_src.sv
// Partner model: external event source on the capture pin
`timescale 1ns/1ps
module ecm_pin_src (
  input logic clock,
  output logic pin
);
  // ----
  // Event source
  // ----
  // Pin rests low between pulses; a pulse call always ends low
  initial pin = 1'b0;
  // Pulses with gap cycles per phase, so slow and prompt edges both occur
  task automatic pulse(input int n, input int gap);
    for (int i = 0; i < n; i++) begin
      repeat (gap) @(posedge clock);
      pin <= 1'b1;
      repeat (gap) @(posedge clock);
      pin <= 1'b0;
    end
  endtask
endmodule

// >>> bench/ecm_unit_chk.sv
// Checker: port timing of the capture/compare unit
`timescale 1ns/1ps
module ecm_unit_chk
  import ecm_pkg::*;
(
  input logic clock,
  input logic rst_n,
  input logic [2:0] avs_address,
  input logic avs_read,
  input logic avs_write,
  input logic [31:0] avs_writedata,
  input logic [31:0] avs_readdata,
  input logic avs_waitrequest,
  input logic timer1_tick,
  input logic adc_enabled,
  input logic capture_compare_pin_in,
  input logic timer1_reset_req,
  input logic adc_start_req,
  input logic unit_interrupt_flag,
  input logic secondary_oe
);
  logic [3:0] mode;
  logic [2:0] age;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  // ----
  // Mode shadow
  // ----
  // Age saturates; checks skip the settling cycles after a mode write
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mode <= 4'h0;
      age <= 3'h0;
    end else if (avs_write && !avs_waitrequest &&
                 avs_address == ADDR_CONTROL) begin
      mode <= avs_writedata[3:0];
      age <= 3'h0;
    end else if (age != 3'h7) begin
      age <= age + 3'h1;
    end
  end
  property p_wait_pulse;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_wait_pulse: assert property (p_wait_pulse) else $error("long ack");
  property p_answer;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_answer: assert property (p_answer) else $error("late ack");
  property p_bit6;
    !avs_waitrequest && avs_read && avs_address == ADDR_CONTROL
      |-> !avs_readdata[6];
  endproperty
  a_bit6: assert property (p_bit6) else $error("bit six set");
  property p_cap;
    age == 3'h7 && mode == MODE_CAP_RISE && $rose(capture_compare_pin_in)
      |-> ##[3:5] unit_interrupt_flag;
  endproperty
  a_cap: assert property (p_cap) else $error("no capture");
  property p_flag_cause;
    $rose(unit_interrupt_flag) && age == 3'h7 && !$past(avs_write)
      |-> !(mode inside {MODE_OFF, MODE_RSV1, MODE_RSV3});
  endproperty
  a_flag_cause: assert property (p_flag_cause) else $error("idle flag");
  property p_sec_oe;
    age == 3'h7 && mode[3:2] != 2'b11 |-> !secondary_oe;
  endproperty
  a_sec_oe: assert property (p_sec_oe) else $error("second pin");
  property p_tmr_reset;
    $rose(timer1_reset_req) |-> $past(timer1_tick) ##1 !timer1_reset_req;
  endproperty
  a_tmr_reset: assert property (p_tmr_reset) else $error("restart");
  property p_adc;
    adc_start_req |-> $past(adc_enabled) ##1 !adc_start_req;
  endproperty
  a_adc: assert property (p_adc) else $error("bad start");
endmodule
bind ecm_unit ecm_unit_chk chk_u (.*);

// >>> bench/ecm_unit_tb.sv
// Testbench: registers, capture, prescaler, compare and special event
`timescale 1ns/1ps
module ecm_unit_tb
  import ecm_pkg::*;
;
  logic clock = 1'b0, rst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic [2:0] avs_address = 3'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata;
  logic [3:0] avs_byteenable = 4'h1;
  logic [9:0] pwm_time_base = 10'h0;
  logic timer1_tick = 1'b0, timer2_period_match = 1'b0;
  logic adc_enabled = 1'b0, port_data_out = 1'b0, capture_compare_pin_in;
  logic avs_waitrequest, timer1_reset_req, adc_start_req;
  logic unit_interrupt_flag, primary_output, primary_oe;
  logic secondary_output, secondary_oe;
  logic [15:0] sixteen_bit_timer_count = 16'h0, rise_at, fall_at, m;
  logic [3:0] hist = 4'h0, co = 4'b0101;
  logic [7:0] q, h;
  int error_cnt = 0, tests_run = 0, adc_seen = 0, clr_seen = 0, a0, c0;
  logic [3:0] cm [4] = '{4'h8, 4'h9, 4'h2, 4'hA};
  logic [3:0] rm [3] = '{4'h1, 4'h3, 4'h0};
  logic [3:0] pm [2] = '{4'h6, 4'h7};
  int pn [2] = '{4, 16};
  ecm_unit dut_u (.*);
  ecm_pin_src src_u (.clock(clock), .pin(capture_compare_pin_in));
  // ----
  // Environment
  // ----
  always #2 clock = ~clock;
  // Timer ticks every other clock; hist marks the cycle the unit sees
  // an edge, the same two stages behind the pin as its detector
  always @(posedge clock) begin
    timer1_tick <= ~timer1_tick;
    if (timer1_reset_req)
      sixteen_bit_timer_count <= 16'h0;
    else if (timer1_tick)
      sixteen_bit_timer_count <= sixteen_bit_timer_count + 16'h1;
    hist <= {hist[2:0], capture_compare_pin_in};
    if (hist[1] && !hist[2])
      rise_at <= sixteen_bit_timer_count;
    if (!hist[1] && hist[2])
      fall_at <= sixteen_bit_timer_count;
    adc_seen <= adc_seen + int'(adc_start_req);
    clr_seen <= clr_seen + int'(timer1_reset_req);
  end
  // ----
  // Tasks
  // ----
  task automatic stop_test;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Request held until waitrequest is sampled low; read data taken there
  task automatic bus(input logic w, input logic [2:0] a, input logic [7:0] d);
    int k;
    k = 0;
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= {24'h0, d};
    @(posedge clock);
    while (avs_waitrequest !== 1'b0 && k < 50) begin
      @(posedge clock);
      k++;
    end
    q = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (k == 50) begin
      error_cnt++;
      stop_test();
    end
    @(posedge clock);
  endtask
  task automatic rc(input logic [2:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk({8'h00, q}, {8'h00, e});
  endtask
  task automatic fl(input logic e);
    chk(16'(unit_interrupt_flag), 16'(e));
  endtask
  task automatic pair(input logic [15:0] e);
    bus(1'b0, ADDR_CCL, 8'h00);
    h = q;
    bus(1'b0, ADDR_CCH, 8'h00);
    chk({q, h}, e);
  endtask
  // Match placed ahead of the running timer, far enough for two writes
  task automatic setm;
    m = sixteen_bit_timer_count + 16'h20;
    bus(1'b1, ADDR_CCL, m[7:0]);
    bus(1'b1, ADDR_CCH, m[15:8]);
  endtask
  task automatic wait_flag;
    int k;
    k = 0;
    while (unit_interrupt_flag !== 1'b1 && k < 400) begin
      @(posedge clock);
      k++;
    end
    fl(1'b1);
    if (k == 400)
      stop_test();
    repeat (4) @(posedge clock);
  endtask
  // ----
  // Scenarios
  // ----
  initial begin
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    rc(ADDR_CONTROL, 8'h00);
    rc(ADDR_PIN_DIR, 8'h01);
    bus(1'b1, 3'h6, 8'hFF);
    rc(3'h6, 8'h00);
    bus(1'b1, ADDR_CONTROL, 8'h41);
    rc(ADDR_CONTROL, 8'h01);
    // Off and reserved codes ignore pin edges
    foreach (rm[i]) begin
      bus(1'b1, ADDR_CONTROL, {4'h0, rm[i]});
      src_u.pulse(2, 3);
      repeat (8) @(posedge clock);
      fl(1'b0);
    end
    // Rising then falling capture; the second edge overwrites the first
    for (int i = 0; i < 2; i++) begin
      bus(1'b1, ADDR_CONTROL, i ? 8'h04 : 8'h05);
      bus(1'b1, ADDR_FLAG, 8'h00);
      src_u.pulse(2, 3);
      repeat (8) @(posedge clock);
      fl(1'b1);
      pair(i ? fall_at : rise_at);
      bus(1'b1, ADDR_FLAG, 8'h00);
      fl(1'b0);
    end
    // Stale prescale count must be dropped by switching off first
    foreach (pm[i]) begin
      bus(1'b1, ADDR_CONTROL, {4'h0, pm[i]});
      src_u.pulse(2, 2);
      bus(1'b1, ADDR_CONTROL, 8'h00);
      bus(1'b1, ADDR_CONTROL, {4'h0, pm[i]});
      bus(1'b1, ADDR_FLAG, 8'h00);
      src_u.pulse(pn[i] - 1, 2);
      repeat (8) @(posedge clock);
      fl(1'b0);
      src_u.pulse(1, 2);
      repeat (8) @(posedge clock);
      fl(1'b1);
      pair(rise_at);
    end
    // Port latch reaches the capture logic when the pin is an output
    bus(1'b1, ADDR_CONTROL, 8'h05);
    bus(1'b1, ADDR_PIN_DIR, 8'h00);
    bus(1'b1, ADDR_FLAG, 8'h00);
    port_data_out <= 1'b1;
    repeat (8) @(posedge clock);
    fl(1'b1);
    // Compare actions in turn, starting from a cleared output latch
    bus(1'b1, ADDR_CONTROL, 8'h00);
    foreach (cm[i]) begin
      bus(1'b1, ADDR_CONTROL, {4'h0, cm[i]});
      bus(1'b1, ADDR_FLAG, 8'h00);
      setm();
      wait_flag();
      chk(16'(primary_output), 16'(co[i]));
    end
    // Special event restarts the timer; conversion start only if enabled
    for (int en = 0; en < 2; en++) begin
      adc_enabled <= en[0];
      bus(1'b1, ADDR_CONTROL, 8'h0B);
      bus(1'b1, ADDR_FLAG, 8'h00);
      a0 = adc_seen;
      c0 = clr_seen;
      setm();
      wait_flag();
      chk(16'(adc_seen - a0), 16'(en));
      chk(16'(clr_seen - c0), 16'h1);
    end
    // PWM: period end turns the output on; half-bridge takes second pin
    bus(1'b1, ADDR_CONTROL, 8'h0C);
    bus(1'b1, ADDR_CCL, 8'h01);
    timer2_period_match <= 1'b1;
    @(posedge clock);
    timer2_period_match <= 1'b0;
    repeat (3) @(posedge clock);
    chk(16'(primary_output), 16'h1);
    chk(16'(primary_oe), 16'h1);
    chk(16'(secondary_oe), 16'h0);
    bus(1'b1, ADDR_CONTROL, 8'h8C);
    repeat (3) @(posedge clock);
    chk(16'(secondary_oe), 16'h1);
    stop_test();
  end
endmodule
